// ===== isp_pkg.sv
/*
 * Shared constants and types for the two-wire slave register port
 * and the master end that drives it.
 * Assumes a single 10 MHz system clock on both ends.
 */


package isp_pkg;

    // ****************************************
    // Timing
    // ****************************************
    localparam int CLK_PERIOD_NS = 100;
    localparam int FS_SPIKE_NS = 50;
    localparam int HS_SPIKE_NS = 10;
    // Stable for one cycle past the longest spike
    localparam int FS_FILT_CYC = FS_SPIKE_NS / CLK_PERIOD_NS + 1;
    localparam int HS_FILT_CYC = HS_SPIKE_NS / CLK_PERIOD_NS + 1;
    localparam int FS_HOLD_NS = 160;
    localparam int HS_HOLD_NS = 80;
    localparam int SDA_DELAY_NS = 120;
    localparam int FS_HOLD_CYC = (FS_HOLD_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int HS_HOLD_CYC = (HS_HOLD_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int SDA_DELAY_CYC = (SDA_DELAY_NS / CLK_PERIOD_NS < 1) ? 1 :
        SDA_DELAY_NS / CLK_PERIOD_NS;
    localparam int FS_TAP = (FS_HOLD_CYC > SDA_DELAY_CYC) ? FS_HOLD_CYC : SDA_DELAY_CYC;
    localparam int HS_TAP = HS_HOLD_CYC;
    localparam int FILT_W = 2;

    // Master SCL quarter periods in system clocks
    localparam int FS_QUARTER_CYC = 7;
    localparam int HS_QUARTER_CYC = 4;
    localparam int QUARTER_W = 4;

    // ****************************************
    // Protocol values
    // ****************************************
    localparam logic [6:0] DEFAULT_ADDR = 7'h40;
    localparam logic [4:0] MASTER_CODE_TOP = 5'h01;
    localparam logic [7:0] PTR_RESET = 8'h00;
    localparam int CMD_W = 10;
    localparam int FIFO_DEPTH = 16;

    typedef enum logic [1:0] {CMD_START, CMD_WRITE, CMD_READ, CMD_STOP} isp_cmd_t;

endpackage : isp_pkg

// ===== isp_bus_if.sv
/*
 * Open-drain two-wire bus joining master and slave ends.
 * Assumes pull-ups: a line is low only where some enabled driver drives low.
 */
`timescale 1ns/1ps
`default_nettype none

interface isp_bus_if;
    logic sclOut;
    logic sclOe;
    logic sdaHostOut;
    logic sdaHostOe;
    logic sdaDevOut;
    logic sdaDevOe;
    logic scl;
    logic sda;

    // ****************************************
    // Wired-AND resolution
    // ****************************************
    assign scl = sclOe ? sclOut : 1'b1;
    assign sda = (sdaHostOe ? sdaHostOut : 1'b1) & (sdaDevOe ? sdaDevOut : 1'b1);

    modport host (output sclOut, output sclOe, output sdaHostOut, output sdaHostOe,
                  input scl, input sda);
    modport dev (output sdaDevOut, output sdaDevOe, input scl, input sda);
endinterface : isp_bus_if

`default_nettype wire

// ===== isp_fifo.sv
/*
 * Synchronous FIFO with valid/ready on both sides.
 * Assumes both sides on clk; ready and valid flags are registered.
 */
`timescale 1ns/1ps
`default_nettype none

module isp_fifo #(
    parameter int WIDTH = 10,
    parameter int DEPTH = 16
) (
    input wire logic clk,
    input wire logic rst,
    input wire logic inValid,
    output logic inReady,
    input wire logic [WIDTH-1:0] inData,
    output logic outValid,
    input wire logic outReady,
    output logic [WIDTH-1:0] outData
);
    localparam int AW = $clog2(DEPTH);

    logic [WIDTH-1:0] mem [DEPTH];
    logic [AW-1:0] wPtr;
    logic [AW-1:0] rPtr;
    logic [AW:0] count;
    logic [AW:0] next_count;
    logic push;
    logic pop;

    assign push = inValid & inReady;
    assign pop = outValid & outReady;
    assign outData = mem[rPtr];

    always_comb begin
        next_count = count;
        if (push && !pop) begin
            next_count = count + 1'b1;
        end else if (pop && !push) begin
            next_count = count - 1'b1;
        end
    end

    always_ff @(posedge clk) begin
        if (push) begin
            mem[wPtr] <= inData;
        end
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            wPtr <= '0;
            rPtr <= '0;
            count <= '0;
            inReady <= 1'b0;
            outValid <= 1'b0;
        end else begin
            if (push) begin
                wPtr <= (wPtr == AW'(DEPTH - 1)) ? '0 : wPtr + 1'b1;
            end
            if (pop) begin
                rPtr <= (rPtr == AW'(DEPTH - 1)) ? '0 : rPtr + 1'b1;
            end
            count <= next_count;
            // Registered flags keep the ready path short; taken from next_count, they leave no slot idle
            inReady <= next_count != (AW + 1)'(DEPTH);
            outValid <= next_count != '0;
        end
    end
endmodule : isp_fifo

`default_nettype wire

// ===== isp_slave_end.sv
/*
 * Slave end of the two-wire register port: START/STOP detection, address
 * match, auto-incrementing pointer and a register-side port.
 * Assumes the register side answers rdData and regValid for regPtr
 * combinationally on clk.
 */
`timescale 1ns/1ps
`default_nettype none

module isp_slave_end import isp_pkg::*; #(
    parameter logic [6:0] SLAVE_ADDR = DEFAULT_ADDR
) (
    input wire logic clk,
    input wire logic rst,
    isp_bus_if.dev bus,
    output logic [7:0] regPtr,
    output logic wrStrobe,
    output logic [7:0] wrData,
    input wire logic [7:0] rdData,
    input wire logic regValid,
    output logic hsMode
);
    typedef enum logic [2:0] {D_IDLE, D_RECV, D_DECIDE, D_ACK, D_LOAD, D_SEND, D_CHECK}
        isp_dstate_t;

    isp_dstate_t state;
    logic [1:0] sclSync;
    logic [1:0] sdaSync;
    logic [1:0] raw;
    logic [1:0] flt;
    logic [FILT_W-1:0] fltCnt [2];
    logic [FILT_W-1:0] filtLen;
    logic [FS_TAP-1:0] sdaDly;
    logic tap;
    logic tapPrev;
    logic sclPrev;
    logic sclRise;
    logic sclFall;
    logic startSeen;
    logic stopSeen;
    logic [3:0] bitCnt;
    logic [7:0] shreg;
    logic [7:0] txByte;
    logic isRead;
    logic addrPhase;
    logic ptrPhase;
    logic ackData;
    logic masterAck;
    logic sdaOe;

    // ****************************************
    // Pin synchronisers and spike filters
    // ****************************************
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            sclSync <= 2'h3;
            sdaSync <= 2'h3;
        end else begin
            sclSync <= {sclSync[0], bus.scl};
            sdaSync <= {sdaSync[0], bus.sda};
        end
    end

    assign raw = {sdaSync[1], sclSync[1]};
    assign filtLen = hsMode ? FILT_W'(HS_FILT_CYC) : FILT_W'(FS_FILT_CYC);

    for (genvar i = 0; i < 2; i++) begin : g_filt
        always_ff @(posedge clk or posedge rst) begin
            if (rst) begin
                flt[i] <= 1'b1;
                fltCnt[i] <= '0;
            end else if (raw[i] != flt[i]) begin
                // A level must outlast the longest spike before it is believed
                if (fltCnt[i] + 1'b1 >= filtLen) begin
                    flt[i] <= raw[i];
                    fltCnt[i] <= '0;
                end else begin
                    fltCnt[i] <= fltCnt[i] + 1'b1;
                end
            end else begin
                fltCnt[i] <= '0;
            end
        end
    end

    // ****************************************
    // SDA hold and bus conditions
    // ****************************************
    // Delayed SDA bridges the SCL falling edge so data changes never look like START/STOP
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            sdaDly <= '1;
            tapPrev <= 1'b1;
            sclPrev <= 1'b1;
        end else begin
            sdaDly <= {sdaDly[FS_TAP-2:0], flt[1]};
            tapPrev <= tap;
            sclPrev <= flt[0];
        end
    end

    assign tap = hsMode ? sdaDly[HS_TAP-1] : sdaDly[FS_TAP-1];
    assign sclRise = flt[0] & ~sclPrev;
    assign sclFall = ~flt[0] & sclPrev;
    assign startSeen = flt[0] & tapPrev & ~tap;
    assign stopSeen = flt[0] & ~tapPrev & tap;
    assign txByte = regValid ? rdData : 8'h00;

    // ****************************************
    // Transfer sequencer
    // ****************************************
    // SCL is never driven here: all steps but D_DECIDE and D_LOAD wait on the master's edges
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            state <= D_IDLE;
            bitCnt <= '0;
            shreg <= '0;
            isRead <= 1'b0;
            addrPhase <= 1'b0;
            ptrPhase <= 1'b0;
            ackData <= 1'b0;
            masterAck <= 1'b0;
            sdaOe <= 1'b0;
        end else if (startSeen) begin
            state <= D_RECV;
            bitCnt <= '0;
            addrPhase <= 1'b1;
            ptrPhase <= 1'b0;
            sdaOe <= 1'b0;
        end else if (stopSeen) begin
            state <= D_IDLE;
            sdaOe <= 1'b0;
        end else begin
            case (state)
                D_RECV: begin
                    if (sclRise) begin
                        shreg <= {shreg[6:0], flt[1]};
                        bitCnt <= bitCnt + 4'h1;
                    end else if (sclFall && bitCnt == 4'h8) begin
                        bitCnt <= '0;
                        state <= D_DECIDE;
                    end
                end
                D_DECIDE: begin
                    ackData <= ~addrPhase & ~ptrPhase;
                    state <= D_ACK;
                    if (addrPhase) begin
                        addrPhase <= 1'b0;
                        if (shreg[7:3] == MASTER_CODE_TOP) begin
                            state <= D_IDLE;
                        end else if (shreg[7:1] == SLAVE_ADDR) begin
                            isRead <= shreg[0];
                            ptrPhase <= ~shreg[0];
                            sdaOe <= 1'b1;
                        end else begin
                            state <= D_IDLE;
                        end
                    end else begin
                        ptrPhase <= 1'b0;
                        sdaOe <= regValid;
                    end
                end
                D_ACK: begin
                    if (sclFall) begin
                        sdaOe <= 1'b0;
                        state <= isRead ? D_LOAD : D_RECV;
                    end
                end
                D_LOAD: begin
                    shreg <= txByte;
                    sdaOe <= ~txByte[7];
                    bitCnt <= '0;
                    state <= D_SEND;
                end
                D_SEND: begin
                    if (sclFall) begin
                        if (bitCnt == 4'h7) begin
                            sdaOe <= 1'b0;
                            bitCnt <= '0;
                            state <= D_CHECK;
                        end else begin
                            shreg <= {shreg[6:0], 1'b0};
                            sdaOe <= ~shreg[6];
                            bitCnt <= bitCnt + 4'h1;
                        end
                    end
                end
                D_CHECK: begin
                    if (sclRise) begin
                        masterAck <= ~flt[1];
                    end else if (sclFall) begin
                        state <= masterAck ? D_LOAD : D_IDLE;
                    end
                end
                D_IDLE: begin
                    sdaOe <= 1'b0;
                end
                default: begin
                    state <= D_IDLE;
                end
            endcase
        end
    end

    // ****************************************
    // Register pointer and register side
    // ****************************************
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            regPtr <= PTR_RESET;
        end else if (state == D_RECV && sclFall && bitCnt == 4'h8 && ptrPhase && !addrPhase) begin
            regPtr <= shreg;
        end else if ((state == D_ACK && sclFall && ackData) || (state == D_CHECK && sclRise)) begin
            regPtr <= regPtr + 8'h01;
        end
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            wrStrobe <= 1'b0;
            wrData <= '0;
        end else begin
            // Bytes at invalid locations never reach the register side
            wrStrobe <= state == D_DECIDE && !addrPhase && !ptrPhase && regValid;
            if (state == D_DECIDE) begin
                wrData <= shreg;
            end
        end
    end

    // Mode flips one clock after the cause, well inside both switch budgets
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            hsMode <= 1'b0;
        end else if (stopSeen) begin
            hsMode <= 1'b0;
        end else if (state == D_DECIDE && addrPhase && shreg[7:3] == MASTER_CODE_TOP) begin
            hsMode <= 1'b1;
        end
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            bus.sdaDevOut <= 1'b0;
        end else begin
            bus.sdaDevOut <= 1'b0;
        end
    end

    assign bus.sdaDevOe = sdaOe;
endmodule : isp_slave_end

`default_nettype wire

// ===== isp_master_end.sv
/*
 * Master end: queues bus commands in a FIFO and plays them out as
 * START, byte write, byte read and STOP on the two-wire bus.
 * Assumes the user side on clk; one response per write or read command.
 */
`timescale 1ns/1ps
`default_nettype none

module isp_master_end import isp_pkg::*; #(
    parameter int FS_QUARTER = FS_QUARTER_CYC,
    parameter int HS_QUARTER = HS_QUARTER_CYC,
    parameter int DEPTH = FIFO_DEPTH
) (
    input wire logic clk,
    input wire logic rst,
    isp_bus_if.host bus,
    input wire logic cmdValid,
    output logic cmdReady,
    input wire logic [CMD_W-1:0] cmdData,
    output logic rspValid,
    output logic [7:0] rspData,
    output logic rspAck,
    output logic hsMode
);
    typedef enum logic [2:0] {H_IDLE, H_HELD, H_START, H_BIT, H_STOP} isp_hstate_t;

    isp_hstate_t state;
    logic fValid;
    logic fReady;
    logic [CMD_W-1:0] fData;
    logic [1:0] sclSync;
    logic [1:0] sdaSync;
    logic [QUARTER_W-1:0] qCnt;
    logic tick;
    logic [1:0] phase;
    logic [3:0] bitCnt;
    logic [8:0] txShift;
    logic [8:0] rxShift;
    logic isRead;
    logic firstByte;
    logic sclOe;
    logic sdaOe;

    // ****************************************
    // Command queue
    // ****************************************
    isp_fifo #(.WIDTH(CMD_W), .DEPTH(DEPTH)) u_cmd_fifo (
        .clk(clk),
        .rst(rst),
        .inValid(cmdValid),
        .inReady(cmdReady),
        .inData(cmdData),
        .outValid(fValid),
        .outReady(fReady),
        .outData(fData)
    );

    // Queue drains only between bus actions, so a busy bus fills it
    assign fReady = (state == H_HELD) ||
        (state == H_IDLE && sclSync[1] && sdaSync[1]);

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            sclSync <= 2'h3;
            sdaSync <= 2'h3;
        end else begin
            sclSync <= {sclSync[0], bus.scl};
            sdaSync <= {sdaSync[0], bus.sda};
        end
    end

    // ****************************************
    // SCL quarter-period divider
    // ****************************************
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            qCnt <= '0;
        end else if (state == H_IDLE || state == H_HELD || tick) begin
            qCnt <= '0;
        end else begin
            qCnt <= qCnt + 1'b1;
        end
    end

    assign tick = qCnt == (hsMode ? QUARTER_W'(HS_QUARTER - 1) : QUARTER_W'(FS_QUARTER - 1));

    // ****************************************
    // Bus sequencer
    // ****************************************
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            state <= H_IDLE;
            phase <= '0;
            bitCnt <= '0;
            txShift <= '1;
            rxShift <= '0;
            isRead <= 1'b0;
            firstByte <= 1'b0;
            sclOe <= 1'b0;
            sdaOe <= 1'b0;
            rspValid <= 1'b0;
            rspData <= '0;
            rspAck <= 1'b0;
            hsMode <= 1'b0;
        end else begin
            rspValid <= 1'b0;
            case (state)
                H_IDLE, H_HELD: begin
                    phase <= '0;
                    bitCnt <= '0;
                    if (fValid && fReady) begin
                        case (isp_cmd_t'(fData[9:8]))
                            CMD_START: state <= H_START;
                            CMD_WRITE: begin
                                txShift <= {fData[7:0], 1'b1};
                                isRead <= 1'b0;
                                state <= H_BIT;
                            end
                            CMD_READ: begin
                                txShift <= {8'hff, ~fData[0]};
                                isRead <= 1'b1;
                                state <= H_BIT;
                            end
                            default: state <= H_STOP;
                        endcase
                    end
                end
                H_START: begin
                    if (tick) begin
                        phase <= phase + 2'h1;
                        case (phase)
                            2'h0: sdaOe <= 1'b0;
                            2'h1: sclOe <= 1'b0;
                            2'h2: sdaOe <= 1'b1;
                            default: begin
                                sclOe <= 1'b1;
                                firstByte <= 1'b1;
                                state <= H_HELD;
                            end
                        endcase
                    end
                end
                H_BIT: begin
                    if (tick) begin
                        phase <= phase + 2'h1;
                        case (phase)
                            2'h0: sdaOe <= ~txShift[8];
                            2'h1: sclOe <= 1'b0;
                            2'h2: sclOe <= 1'b0;
                            default: begin
                                sclOe <= 1'b1;
                                rxShift <= {rxShift[7:0], sdaSync[1]};
                                txShift <= {txShift[7:0], 1'b1};
                                bitCnt <= bitCnt + 4'h1;
                                if (bitCnt == 4'h8) begin
                                    state <= H_HELD;
                                    rspValid <= 1'b1;
                                    rspData <= rxShift[7:0];
                                    rspAck <= ~sdaSync[1];
                                    firstByte <= 1'b0;
                                    // Only the first byte after START can be a master code
                                    if (firstByte && !isRead &&
                                            rxShift[7:3] == MASTER_CODE_TOP) begin
                                        hsMode <= 1'b1;
                                    end
                                end
                            end
                        endcase
                    end
                end
                H_STOP: begin
                    if (tick) begin
                        phase <= phase + 2'h1;
                        case (phase)
                            2'h0: sdaOe <= 1'b1;
                            2'h1: sclOe <= 1'b0;
                            default: begin
                                sdaOe <= 1'b0;
                                hsMode <= 1'b0;
                                state <= H_IDLE;
                            end
                        endcase
                    end
                end
                default: state <= H_IDLE;
            endcase
        end
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            bus.sclOut <= 1'b0;
            bus.sdaHostOut <= 1'b0;
        end else begin
            bus.sclOut <= 1'b0;
            bus.sdaHostOut <= 1'b0;
        end
    end

    assign bus.sclOe = sclOe;
    assign bus.sdaHostOe = sdaOe;
endmodule : isp_master_end

`default_nettype wire

// ===== isp_props.sv
/* Bus checker: slave drive on the two-wire link against the resolved lines.
   Assumes clk runs many times faster than SCL. */
`timescale 1ns/1ps
`default_nettype none
module isp_props import isp_pkg::*; (
    input wire logic clk,
    input wire logic rst,
    input wire logic scl,
    input wire logic sda,
    input wire logic sdaDevOut,
    input wire logic sdaDevOe
);
    logic pScl, pSda, first, rd;
    logic [3:0] pos;
    logic [7:0] sh;
    wire logic rise = scl & ~pScl;
    wire logic begun = pScl & scl & pSda & ~sda;
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            pScl <= 1'h1;
            pSda <= 1'h1;
        end else begin
            pScl <= scl;
            pSda <= sda;
        end
    end
    // Bit position since the last START; the ninth bit is the acknowledge
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            pos <= 4'h0;
            first <= 1'h1;
            rd <= 1'h0;
            sh <= 8'h00;
        end else if (begun) begin
            pos <= 4'h0;
            first <= 1'h1;
        end else if (rise) begin
            pos <= (pos == 4'h8) ? 4'h0 : pos + 4'h1;
            sh <= {sh[6:0], sda};
            first <= first & (pos != 4'h8);
            rd <= (first && pos == 4'h7) ? sda : rd;
        end
    end
    // ****************
    // Properties
    // ****************
    default clocking cb @(posedge clk); endclocking
    default disable iff (rst);
    AST_OPEN_DRAIN: assert property (sdaDevOe |-> !sdaDevOut)
        else $error("slave drives sda high");
    AST_STEADY_HIGH: assert property (scl && pScl |-> $stable(sdaDevOe))
        else $error("slave moved sda while scl high");
    AST_ADDR_ACK: assert property ($fell(scl) && first && pos == 4'h8 && sh[7:1] == DEFAULT_ADDR
        |-> ##[1:8] sdaDevOe)
        else $error("own address not acknowledged");
    AST_ADDR_MISS: assert property (first && pos == 4'h8 && sh[7:1] != DEFAULT_ADDR
        |-> !sdaDevOe)
        else $error("foreign address or master code acknowledged");
    AST_ADDR_QUIET: assert property (first && pos < 4'h8 |-> !sdaDevOe)
        else $error("slave drove during address byte");
    AST_ACK_HOLD: assert property (rise && pos == 4'h8 && sdaDevOe |-> sdaDevOe [*6])
        else $error("acknowledge dropped during scl high");
    AST_NACK_RELEASE: assert property (rise && pos == 4'h8 && rd && !first && sda
        |=> !sdaDevOe [*8] ##1 !sdaDevOe [*8] ##1 !sdaDevOe [*8])
        else $error("slave kept sda after read nack");
    AST_STOP_QUIET: assert property (pScl && scl && !pSda && sda |-> !sdaDevOe [*8])
        else $error("slave drove after stop");
    CV_START: cover property (begun);
    CV_ADDR_ACK: cover property (first && pos == 4'h8 && sdaDevOe);
    CV_READ_END: cover property (rise && pos == 4'h8 && rd && !first && sda);
endmodule : isp_props
`default_nettype wire

// ===== isp_port_test.sv
/* Bench: master end drives slave end over the bus; a register array sits on the slave side.
   Assumes package, interface, FIFO, both ends and the checker compiled first. */
`timescale 1ns/1ps
`default_nettype none
module isp_port_test import isp_pkg::*;;
    logic clk = 1'h0;
    logic rst = 1'h1;
    logic cmdValid = 1'h0;
    logic [CMD_W-1:0] cmdData = '0;
    logic cmdReady, rspValid, rspAck, hsHost, hsDev, wrStrobe;
    logic [7:0] rspData, regPtr, wrData;
    logic [7:0] regs [256];
    logic [9:0] expQ [$];
    int n_fail = 0;
    int n_checks = 0;
    // Valid places 00-07 and ff, so the wrap crosses valid ground
    wire logic regValid = (regPtr < 8'h08) || (regPtr == 8'hff);
    wire logic [7:0] rdData = regs[regPtr];
    isp_bus_if bus();
    isp_master_end i_isp_master_end (.clk(clk), .rst(rst), .bus(bus), .cmdValid(cmdValid),
        .cmdReady(cmdReady), .cmdData(cmdData), .rspValid(rspValid), .rspData(rspData),
        .rspAck(rspAck), .hsMode(hsHost));
    isp_slave_end i_isp_slave_end (.clk(clk), .rst(rst), .bus(bus), .regPtr(regPtr),
        .wrStrobe(wrStrobe), .wrData(wrData), .rdData(rdData), .regValid(regValid),
        .hsMode(hsDev));
    isp_props i_isp_props (.clk(clk), .rst(rst), .scl(bus.scl), .sda(bus.sda),
        .sdaDevOut(bus.sdaDevOut), .sdaDevOe(bus.sdaDevOe));
    initial begin
        forever #50 clk = ~clk;
    end
    always @(posedge clk) begin
        if (wrStrobe === 1'h1) regs[regPtr] <= wrData;
        if (rspValid === 1'h1 && expQ.size() != 0) begin
            if (expQ[0][9]) chk("read byte", expQ[0][7:0], rspData);
            else chk("ack bit", {7'h0, expQ[0][8]}, {7'h0, rspAck});
            void'(expQ.pop_front());
        end
    end
    // ****************
    // Access tasks
    // ****************
    task chk(input string what, input logic [7:0] exp, input logic [7:0] got);
        n_checks++;
        if (got !== exp) begin
            n_fail++;
            $display("Error %s expected %h seen %h", what, exp, got);
        end
    endtask : chk
    task push(input logic [9:0] cmd);
        @(posedge clk) #1;
        for (int w = 0; w < 2000 && cmdReady !== 1'h1; w++) @(posedge clk) #1;
        cmdValid = 1'h1;
        cmdData = cmd;
        @(posedge clk) #1 cmdValid = 1'h0;
    endtask : push
    task wr(input logic [7:0] b, input logic ack);
        expQ.push_back({1'h0, ack, b});
        push({CMD_WRITE, b});
    endtask : wr
    task rd(input logic ackOut, input logic [7:0] exp);
        expQ.push_back({2'h2, exp});
        push({CMD_READ, 7'h00, ackOut});
    endtask : rd
    task st;
        push({CMD_START, 8'h00});
    endtask : st
    task drain;
        for (int w = 0; w < 6000 && expQ.size() != 0; w++) @(posedge clk);
        chk("pending", 8'h00, 8'(expQ.size()));
    endtask : drain
    task sp;
        push({CMD_STOP, 8'h00});
        drain();
        repeat (100) @(posedge clk);
    endtask : sp
    task results;
        $display("Checks %0d mismatches %0d", n_checks, n_fail);
        if (n_fail == 0 && n_checks > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask : results
    // Whole run needs about 6400 clocks
    initial begin
        #4000000 n_fail++;
        results();
    end
    initial begin
        for (int i = 0; i < 256; i++) regs[i] = {1'h1, i[6:0]};
        repeat (3) @(posedge clk);
        #1 rst = 1'h0;
        st();
        wr(8'h80, 1'h1);
        wr(8'h01, 1'h1);
        wr(8'haa, 1'h1);
        wr(8'h55, 1'h1);
        sp();
        chk("reg 01", 8'haa, regs[1]);
        chk("reg 02", 8'h55, regs[2]);
        st();
        wr(8'h81, 1'h1);
        rd(1'h1, 8'h83);
        rd(1'h0, 8'h84);
        sp();
        st();
        wr(8'h80, 1'h1);
        wr(8'hfe, 1'h0);
        wr(8'h11, 1'h0);
        wr(8'h22, 1'h1);
        wr(8'h33, 1'h1);
        sp();
        chk("reg fe", 8'hfe, regs[254]);
        chk("reg ff", 8'h22, regs[255]);
        chk("reg 00", 8'h33, regs[0]);
        st();
        wr(8'h80, 1'h1);
        wr(8'h06, 1'h1);
        st();
        wr(8'h81, 1'h1);
        rd(1'h1, 8'h86);
        rd(1'h1, 8'h87);
        rd(1'h0, 8'h00);
        sp();
        st();
        wr(8'h90, 1'h0);
        sp();
        st();
        wr(8'h08, 1'h0);
        drain();
        chk("slave hs", 8'h01, {7'h0, hsDev});
        chk("host hs", 8'h01, {7'h0, hsHost});
        st();
        wr(8'h80, 1'h1);
        wr(8'h07, 1'h1);
        st();
        wr(8'h81, 1'h1);
        rd(1'h1, 8'h87);
        rd(1'h0, 8'h00);
        sp();
        chk("slave fs", 8'h00, {7'h0, hsDev});
        chk("host fs", 8'h00, {7'h0, hsHost});
        results();
    end
endmodule : isp_port_test
`default_nettype wire
